// ---- hw/mmpcl_pkg.sv ----
/*
 * Package of the multi-mode pin configuration loader: register map,
 * reset values, timing counts, pin encodings and decode tables.
 * Assumes a single 40 MHz clock and 32-bit AXI4-Lite register access.
 */
package mmpcl_pkg;

	// Timing
	localparam int CLK_FREQ_HZ    = 40_000_000;
	localparam int LOAD_TIME_MS   = 5;
	localparam int LOAD_CYCLES    =
		(LOAD_TIME_MS * (CLK_FREQ_HZ / 1000) + 0);
	localparam int LOAD_CNT_W     = 18;
	localparam int MIN_OFF_NS     = 150;
	localparam int MIN_OFF_CYCLES =
		(MIN_OFF_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL       = 8'h00;
	localparam logic [7:0] OFF_STATUS     = 8'h04;
	localparam logic [7:0] OFF_VOUT       = 8'h08;
	localparam logic [7:0] OFF_VOUT_CEIL  = 8'h0C;
	localparam logic [7:0] OFF_BUS_ADDR   = 8'h10;
	localparam logic [7:0] OFF_FREQ_SEL   = 8'h14;
	localparam logic [7:0] OFF_UVLO       = 8'h18;
	localparam logic [7:0] OFF_COMP       = 8'h1C;
	localparam logic [7:0] OFF_UV_THRESH  = 8'h20;
	localparam logic [7:0] OFF_OV_THRESH  = 8'h24;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h28;
	localparam logic [7:0] OFF_IRQ_MASK   = 8'h2C;

	// Field positions
	localparam int CTRL_RESTORE_BIT = 0;
	localparam int CTRL_SW_EN_BIT   = 1;
	localparam int IRQ_LOAD_DONE    = 0;
	localparam int IRQ_UNDERVOLT    = 1;
	localparam int IRQ_OVERVOLT     = 2;
	localparam int IRQ_W            = 3;

	// Reset values, bus responses, resistor code limit and pin indices
	localparam logic [15:0] VOUT_RESET      = 16'h04B0;
	localparam logic [1:0]  FREQ_RESET      = 2'h1;
	localparam logic [5:0]  UVLO_RESET      = 6'h00;
	localparam logic [15:0] COMP_RESET      = 16'h1040;
	localparam logic [15:0] UV_RESET        = 16'h0000;
	localparam logic [15:0] OV_RESET        = 16'hFFFF;
	localparam logic [6:0]  BUS_ADDR_BASE   = 7'h20;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	localparam logic [4:0]  RES_CODE_LAST   = 5'h1E;
	localparam int          NUM_PINS        = 4;
	localparam int          PIN_ADDR        = 0;
	localparam int          PIN_OUTPUT_VOLTAGE_SELECT_PIN        = 1;
	localparam int          PIN_FREQ        = 2;
	localparam int          PIN_UVLO        = 3;

	typedef enum logic [1:0] {
		KIND_LOW  = 2'b00,
		KIND_OPEN = 2'b01,
		KIND_HIGH = 2'b10,
		KIND_RES  = 2'b11
	} mmpcl_kind_t;

	// Comparator and resistance-sense results of one pin
	typedef struct packed {
		logic       below_low;
		logic       above_high;
		logic       res_valid;
		logic [4:0] res_code;
	} mmpcl_pin_raw_t;

	typedef struct packed {
		mmpcl_kind_t kind;
		logic [4:0]  code;
	} mmpcl_setting_t;

	// Switching period in clock cycles per frequency select
	function automatic logic [7:0] period_cycles(input logic [1:0] sel);
		unique case (sel)
			2'h0: period_cycles = 8'h28;
			2'h1: period_cycles = 8'h50;
			2'h2: period_cycles = 8'hA0;
			2'h3: period_cycles = 8'hC8;
		endcase
	endfunction

	// Linear selection index: low, open, high, then resistor codes
	function automatic logic [5:0] setting_index(input mmpcl_setting_t s);
		unique case (s.kind)
			KIND_LOW:  setting_index = 6'h00;
			KIND_OPEN: setting_index = 6'h01;
			KIND_HIGH: setting_index = 6'h02;
			KIND_RES:  setting_index = 6'(s.code) + 6'h03;
		endcase
	endfunction

	// Output voltage target in millivolts
	function automatic logic [15:0] output_voltage_select_pin_mv(input mmpcl_setting_t s);
		logic [15:0] tbl [31];
		tbl = '{16'h0258, 16'h02BC, 16'h02EE, 16'h0320, 16'h0384,
			16'h03E8, 16'h044C, 16'h04B0, 16'h04E2, 16'h0514,
			16'h0578, 16'h05DC, 16'h0640, 16'h06A4, 16'h0708,
			16'h076C, 16'h07D0, 16'h0834, 16'h0898, 16'h08FC,
			16'h0960, 16'h09C4, 16'h0A28, 16'h0A8C, 16'h0AF0,
			16'h0B54, 16'h0BB8, 16'h0C1C, 16'h0C80, 16'h0CE4,
			16'h1388};
		unique case (s.kind)
			KIND_LOW:  output_voltage_select_pin_mv = 16'h04B0;
			KIND_OPEN: output_voltage_select_pin_mv = 16'h05DC;
			KIND_HIGH: output_voltage_select_pin_mv = 16'h0CE4;
			KIND_RES:  output_voltage_select_pin_mv = tbl[s.code];
		endcase
	endfunction

	function automatic logic [31:0] apply_strb(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		apply_strb = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				apply_strb[8*i +: 8] = nw[8*i +: 8];
			end
		end
	endfunction

endpackage

// ---- hw/mmpcl_pin_decoder.sv ----
/*
 * Decoder of one multi-mode configuration pin.
 * Assumes comparator and resistance-sense results synchronous to aclk.
 */
`timescale 1ns/100ps
module mmpcl_pin_decoder (
	// Clock and reset
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// Capture request
	input  wire logic                     sample,
	// Pin sense results
	input  wire mmpcl_pkg::mmpcl_pin_raw_t raw,
	// Held setting
	output mmpcl_pkg::mmpcl_setting_t     setting
);
	import mmpcl_pkg::*;

	mmpcl_setting_t setting_reg;
	mmpcl_setting_t setting_next;

	always_comb begin
		setting_next.code = 5'h00;
		if (raw.below_low) begin
			setting_next.kind = KIND_LOW;
		end else if (raw.above_high) begin
			setting_next.kind = KIND_HIGH;
		end else if (raw.res_valid && raw.res_code <= RES_CODE_LAST) begin
			setting_next.kind = KIND_RES;
			setting_next.code = raw.res_code;
		end else begin
			setting_next.kind = KIND_OPEN;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			setting_reg <= '{kind: KIND_OPEN, code: 5'h00};
		end else if (sample) begin
			setting_reg <= setting_next;
		end
	end

	assign setting = setting_reg;

endmodule // mmpcl_pin_decoder

// ---- hw/mmpcl_loader.sv ----
/*
 * Configuration loader of a digital step-down converter: pin capture,
 * stored-value load, register file over AXI4-Lite, compensation filter,
 * switching modulator and threshold alerts.
 * Assumes one 40 MHz clock; pin, error and measurement inputs are
 * synchronous to it.
 */
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps

module mmpcl_loader #(
	parameter int LOAD_CYCLES_P = mmpcl_pkg::LOAD_CYCLES
) (
	// Clock and reset
	input  wire logic                                   aclk,
	input  wire logic                                   aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]                             s_axi_awaddr,
	input  wire logic                                   s_axi_awvalid,
	output logic                                        s_axi_awready,
	input  wire logic [31:0]                            s_axi_wdata,
	input  wire logic [3:0]                             s_axi_wstrb,
	input  wire logic                                   s_axi_wvalid,
	output logic                                        s_axi_wready,
	output logic [1:0]                                  s_axi_bresp,
	output logic                                        s_axi_bvalid,
	input  wire logic                                   s_axi_bready,
	input  wire logic [7:0]                             s_axi_araddr,
	input  wire logic                                   s_axi_arvalid,
	output logic                                        s_axi_arready,
	output logic [31:0]                                 s_axi_rdata,
	output logic [1:0]                                  s_axi_rresp,
	output logic                                        s_axi_rvalid,
	input  wire logic                                   s_axi_rready,
	// Multi-mode pins
	input  wire mmpcl_pkg::mmpcl_pin_raw_t [3:0]        pins_raw,
	// Stored user values
	input  wire logic                                   nvm_present,
	input  wire logic [15:0]                            nvm_vout,
	input  wire logic [1:0]                             nvm_freq_sel,
	// Enable and loop
	input  wire logic                                   enable_pin,
	input  wire logic                                   err_valid,
	input  wire logic signed [11:0]                     err_sample,
	input  wire logic                                   vout_meas_valid,
	input  wire logic [15:0]                            vout_meas,
	// Switch drive and status
	output logic                                        high_side_on,
	output logic                                        low_side_on,
	output logic                                        config_ready,
	output logic                                        irq
);
	import mmpcl_pkg::*;

	typedef enum logic [1:0] {
		ST_POWERUP = 2'b00,
		ST_MEMCHK  = 2'b01,
		ST_PINLOAD = 2'b10,
		ST_READY   = 2'b11
	} mmpcl_state_t;

	mmpcl_state_t             state_reg;
	logic [LOAD_CNT_W-1:0]    load_cnt_reg;
	mmpcl_setting_t [3:0]     pin_set;
	logic                     sample;
	logic                     load_end;
	logic                     bus_open;
	logic                     aw_held_reg, w_held_reg, bvalid_reg;
	logic [7:0]               awaddr_reg;
	logic [31:0]              wdata_reg;
	logic [3:0]               wstrb_reg;
	logic                     wr_fire;
	logic [31:0]              wr_val;
	logic                     rvalid_reg;
	logic [31:0]              rdata_reg;
	logic [1:0]               rresp_reg, bresp_reg;
	logic                     restore_req;
	logic                     sw_en_reg;
	logic [15:0]              vout_reg, ceil_reg, uv_reg, ov_reg, comp_reg;
	logic [6:0]               bus_addr_reg;
	logic [1:0]               freq_reg;
	logic [5:0]               uvlo_reg;
	logic [IRQ_W-1:0]         irq_stat_reg, irq_mask_reg, irq_evt;
	logic                     rd_clear;
	logic                     run;
	logic [7:0]               period, duty_max, pwm_cnt_reg, duty_reg;
	logic signed [23:0]       integ_reg, integ_sum, duty_acc;
	logic signed [20:0]       p_term, i_term;
	logic [7:0]               duty_next;
	logic [16:0]              ceil_calc;
	logic                     hs_reg, ls_reg;
	logic                     done_evt;

	// Pin decoders
	for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
		mmpcl_pin_decoder u_dec (
			.aclk    (aclk),
			.aresetn (aresetn),
			.sample  (sample),
			.raw     (pins_raw[i]),
			.setting (pin_set[i])
		);
	end

	// Load sequencing
	assign load_end = (state_reg == ST_MEMCHK) &&
		(load_cnt_reg >= LOAD_CNT_W'(LOAD_CYCLES_P - 1));
	assign sample   = load_end;
	assign bus_open = (state_reg == ST_READY);
	assign done_evt = (state_reg == ST_PINLOAD);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg    <= ST_POWERUP;
			load_cnt_reg <= '0;
		end else begin
			unique case (state_reg)
				ST_POWERUP: state_reg <= ST_MEMCHK;
				ST_MEMCHK: begin
					load_cnt_reg <= load_cnt_reg + 1'b1;
					if (load_end) begin
						state_reg <= ST_PINLOAD;
					end
				end
				ST_PINLOAD: state_reg <= ST_READY;
				ST_READY: begin
					load_cnt_reg <= '0;
					if (restore_req) begin
						state_reg <= ST_MEMCHK;
					end
				end
			endcase
		end
	end

	// Write channel
	assign s_axi_awready = bus_open && !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = bus_open && !w_held_reg && !bvalid_reg;
	assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wr_val        = apply_strb(32'h0, wdata_reg, wstrb_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			awaddr_reg  <= 8'h00;
			wdata_reg   <= 32'h0;
			wstrb_reg   <= 4'h0;
			bresp_reg   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				unique case (awaddr_reg)
					OFF_CTRL, OFF_VOUT, OFF_FREQ_SEL, OFF_UVLO,
					OFF_COMP, OFF_UV_THRESH, OFF_OV_THRESH,
					OFF_IRQ_MASK: bresp_reg <= RESP_OKAY;
					default:      bresp_reg <= RESP_SLVERR;
				endcase
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	assign restore_req = wr_fire && awaddr_reg == OFF_CTRL &&
		wstrb_reg[0] && wdata_reg[CTRL_RESTORE_BIT];

	// Configuration registers: stored values, then pins, then host
	assign ceil_calc = (17'(output_voltage_select_pin_mv(pin_set[PIN_OUTPUT_VOLTAGE_SELECT_PIN])) * 17'd11) /
		17'd10;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vout_reg     <= VOUT_RESET;
			freq_reg     <= FREQ_RESET;
			uvlo_reg     <= UVLO_RESET;
			ceil_reg     <= 16'h0000;
			bus_addr_reg <= BUS_ADDR_BASE;
			comp_reg     <= COMP_RESET;
			uv_reg       <= UV_RESET;
			ov_reg       <= OV_RESET;
			sw_en_reg    <= 1'b0;
			irq_mask_reg <= '0;
		end else if (load_end && nvm_present) begin
			vout_reg <= nvm_vout;
			freq_reg <= nvm_freq_sel;
		end else if (state_reg == ST_PINLOAD) begin
			bus_addr_reg <= BUS_ADDR_BASE +
				7'(setting_index(pin_set[PIN_ADDR]));
			ceil_reg     <= ceil_calc[15:0];
			if (!nvm_present || pin_set[PIN_OUTPUT_VOLTAGE_SELECT_PIN].kind != KIND_OPEN) begin
				vout_reg <= output_voltage_select_pin_mv(pin_set[PIN_OUTPUT_VOLTAGE_SELECT_PIN]);
			end
			if (!nvm_present || pin_set[PIN_FREQ].kind != KIND_OPEN) begin
				freq_reg <= 2'(setting_index(pin_set[PIN_FREQ]));
			end
			uvlo_reg <= setting_index(pin_set[PIN_UVLO]);
		end else if (wr_fire) begin
			unique case (awaddr_reg)
				OFF_CTRL:      sw_en_reg <= wr_val[CTRL_SW_EN_BIT];
				OFF_VOUT:      vout_reg  <= (wr_val[15:0] > ceil_reg) ?
					ceil_reg : wr_val[15:0];
				OFF_FREQ_SEL:  freq_reg  <= wr_val[1:0];
				OFF_UVLO:      uvlo_reg  <= wr_val[5:0];
				OFF_COMP:      comp_reg  <= wr_val[15:0];
				OFF_UV_THRESH: uv_reg    <= wr_val[15:0];
				OFF_OV_THRESH: ov_reg    <= wr_val[15:0];
				OFF_IRQ_MASK:  irq_mask_reg <= wr_val[IRQ_W-1:0];
				default:       ;
			endcase
		end
	end

	// Read channel
	assign s_axi_arready = bus_open && !rvalid_reg;
	assign rd_clear = s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == OFF_IRQ_STATUS;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0;
			rresp_reg  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= RESP_OKAY;
			rdata_reg  <= 32'h0;
			unique case (s_axi_araddr)
				OFF_CTRL:      rdata_reg <= {30'h0, sw_en_reg, 1'b0};
				OFF_STATUS:    rdata_reg <= {30'h0, state_reg};
				OFF_VOUT:      rdata_reg <= {16'h0, vout_reg};
				OFF_VOUT_CEIL: rdata_reg <= {16'h0, ceil_reg};
				OFF_BUS_ADDR:  rdata_reg <= {25'h0, bus_addr_reg};
				OFF_FREQ_SEL:  rdata_reg <= {30'h0, freq_reg};
				OFF_UVLO:      rdata_reg <= {26'h0, uvlo_reg};
				OFF_COMP:      rdata_reg <= {16'h0, comp_reg};
				OFF_UV_THRESH: rdata_reg <= {16'h0, uv_reg};
				OFF_OV_THRESH: rdata_reg <= {16'h0, ov_reg};
				OFF_IRQ_STATUS: rdata_reg <= {29'h0, irq_stat_reg};
				OFF_IRQ_MASK:  rdata_reg <= {29'h0, irq_mask_reg};
				default:       rresp_reg <= RESP_SLVERR;
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Alerts: set wins over read-clear
	assign irq_evt[IRQ_LOAD_DONE] = done_evt;
	assign irq_evt[IRQ_UNDERVOLT] = run && vout_meas_valid &&
		vout_meas < uv_reg;
	assign irq_evt[IRQ_OVERVOLT]  = run && vout_meas_valid &&
		vout_meas > ov_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= (rd_clear ? '0 : irq_stat_reg) | irq_evt;
		end
	end

	// Compensation filter
	assign run = bus_open && (enable_pin || sw_en_reg);
	assign p_term = $signed({1'b0, comp_reg[7:0]}) * err_sample;
	assign i_term = $signed({1'b0, comp_reg[15:8]}) * err_sample;
	assign integ_sum = integ_reg + 24'(i_term);
	assign duty_acc  = integ_sum + 24'(p_term);
	assign period    = period_cycles(freq_reg);
	assign duty_max  = period - 8'(MIN_OFF_CYCLES);

	always_comb begin
		if (duty_acc[23]) begin
			duty_next = 8'h00;
		end else if (duty_acc[23:8] > {8'h00, duty_max}) begin
			duty_next = duty_max;
		end else begin
			duty_next = duty_acc[15:8];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			integ_reg <= 24'h000000;
		end else if (err_valid) begin
			integ_reg <= integ_sum;
		end
	end

	// Modulator
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			pwm_cnt_reg <= 8'h00;
			duty_reg    <= 8'h00;
			hs_reg      <= 1'b0;
			ls_reg      <= 1'b0;
		end else begin
			if (pwm_cnt_reg >= period - 8'h01) begin
				pwm_cnt_reg <= 8'h00;
				duty_reg    <= duty_next;
			end else begin
				pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
			end
			hs_reg <= pwm_cnt_reg < duty_reg;
			ls_reg <= !(pwm_cnt_reg < duty_reg);
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;
	assign high_side_on = hs_reg;
	assign low_side_on  = ls_reg;
	assign config_ready = bus_open;
	assign irq          = |(irq_stat_reg & irq_mask_reg);

endmodule // mmpcl_loader

// ---- verif/mmpcl_strap_model.sv ----
/*
 * Board strapping model: turns the chosen connection of each pin into
 * comparator and resistance-sense results.
 * Assumes the bench picks a kind and a resistor code for every pin.
 */
`timescale 1ns/100ps
module mmpcl_strap_model (
	// Connection chosen per pin
	input  wire logic [3:0][1:0]                 kind,
	input  wire logic [3:0][4:0]                 code,
	// Sense results
	output mmpcl_pkg::mmpcl_pin_raw_t [3:0]      raw
);
	import mmpcl_pkg::*;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			raw[i].below_low  = (kind[i] == KIND_LOW);
			raw[i].above_high = (kind[i] == KIND_HIGH);
			raw[i].res_valid  = (kind[i] == KIND_RES);
			// Code stays visible when open, as a floating sense would
			raw[i].res_code   = code[i];
		end
	end
endmodule // mmpcl_strap_model

// ---- verif/mmpcl_loader_sva.sv ----
/*
 * Checker of bus handshakes, load wait and switch drive of the loader.
 * Assumes binding to mmpcl_loader with its load-wait parameter.
 */
`timescale 1ns/100ps
module mmpcl_loader_sva #(
	parameter int LOAD_CYCLES_P = 20
) (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Drive and status
	input wire logic        high_side_on,
	input wire logic        low_side_on,
	input wire logic        config_ready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	int unsigned wait_cnt;
	// Cycles spent since the loader last left the ready state
	always_ff @(posedge aclk) begin
		if (!aresetn || config_ready) begin
			wait_cnt <= 0;
		end else begin
			wait_cnt <= wait_cnt + 1;
		end
	end
	chk_bus_closed: assert property (!config_ready |-> !s_axi_awready &&
		!s_axi_wready && !s_axi_arready) else $error("bus open while loading");
	chk_load_time: assert property ($rose(config_ready) |->
		wait_cnt >= LOAD_CYCLES_P && wait_cnt <= LOAD_CYCLES_P + 2)
		else $error("load wait length wrong");
	chk_idle_drive: assert property (!config_ready && $past(!config_ready)
		|-> !high_side_on && !low_side_on) else $error("switching while loading");
	chk_no_overlap: assert property (!(high_side_on && low_side_on))
		else $error("both switches on");
	chk_min_low: assert property ($fell(high_side_on) |->
		(!high_side_on)[*6]) else $error("low-side interval too short");
	chk_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("no write response");
	chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("no read data");
	chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata changed");
	chk_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during response");
	cov_load: cover property ($rose(config_ready));
	cov_switch: cover property ($fell(high_side_on));
	cov_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // mmpcl_loader_sva

// ---- verif/mmpcl_loader_tb_top.sv ----
/*
 * Bench of the pin configuration loader: register access over AXI4-Lite,
 * pin decode through restore, stored values, interrupts, modulator.
 * Assumes the strap model on the pins and a shortened load wait.
 */
`timescale 1ns/100ps
module mmpcl_loader_tb_top;
	import mmpcl_pkg::*;
	localparam int LC = 20;
	logic                  aclk, aresetn, awvalid, wvalid, bready;
	logic                  arvalid, rready, awready, wready, bvalid;
	logic                  arready, rvalid, nvm_present, enable_pin;
	logic                  err_valid, vm_valid, hs_on, ls_on, cfg_rdy, irq;
	logic [7:0]            awaddr, araddr;
	logic [31:0]           wdata, rdata, d;
	logic [1:0]            bresp, rresp, rsp, nvm_freq_sel;
	logic [15:0]           nvm_vout, vout_meas;
	logic signed [11:0]    err_sample;
	logic [3:0][1:0]       kind;
	logic [3:0][4:0]       code;
	mmpcl_pin_raw_t [3:0]  pins_raw;
	int                    failures, n_checks, n_hs, n_ls;
	logic [1:0]  tk [6] = '{KIND_LOW, KIND_OPEN, KIND_HIGH, KIND_RES,
		KIND_RES, KIND_RES};
	logic [4:0]  tc [6] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h1E, 5'h1F};
	logic [5:0]  ti [6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h21, 6'h01};
	logic [15:0] tv [6] = '{16'h04B0, 16'h05DC, 16'h0CE4, 16'h0258,
		16'h1388, 16'h05DC};
	mmpcl_strap_model strap_u (.kind(kind), .code(code), .raw(pins_raw));
	mmpcl_loader #(.LOAD_CYCLES_P(LC)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins_raw(pins_raw),
		.nvm_present(nvm_present), .nvm_vout(nvm_vout),
		.nvm_freq_sel(nvm_freq_sel), .enable_pin(enable_pin),
		.err_valid(err_valid), .err_sample(err_sample),
		.vout_meas_valid(vm_valid), .vout_meas(vout_meas),
		.high_side_on(hs_on), .low_side_on(ls_on), .config_ready(cfg_rdy),
		.irq(irq));
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Handshakes are judged on settled values between edges
	task automatic wrc(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] er);
		logic ta, tw, tb;
		int t;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tb = 1'b0;
		for (t = 0; t < 500 && !tb; t++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			rsp = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end
		chk(32'(tb), 32'h1);
		chk(32'(rsp), 32'(er));
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic ta, tr;
		int t;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		tr = 1'b0;
		for (t = 0; t < 500 && !tr; t++) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid && rready;
			d = rdata;
			rsp = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end
		chk(32'(tr), 32'h1);
		chk(d, e);
		chk(32'(rsp), 32'(er));
	endtask
	task automatic wait_ready;
		int t;
		@(negedge aclk);
		for (t = 0; t < 500 && cfg_rdy !== 1'b1; t++) @(negedge aclk);
		chk(32'(cfg_rdy), 32'h1);
		@(posedge aclk);
	endtask
	task automatic restore;
		wrc(OFF_CTRL, 32'h1, RESP_OKAY);
		wait_ready();
	endtask
	task automatic conclude;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		conclude();
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, nvm_present, nvm_vout, nvm_freq_sel} = '0;
		{enable_pin, err_valid, err_sample, vm_valid, vout_meas} = '0;
		kind = {4{KIND_LOW}};
		code = '0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		wait_ready();
		rdc(OFF_STATUS, 32'h3, RESP_OKAY);
		rdc(OFF_COMP, 32'(COMP_RESET), RESP_OKAY);
		rdc(OFF_OV_THRESH, 32'(OV_RESET), RESP_OKAY);
		rdc(OFF_UV_THRESH, 32'(UV_RESET), RESP_OKAY);
		for (int i = 0; i < 6; i++) begin
			kind <= {4{tk[i]}};
			code <= {4{tc[i]}};
			restore();
			rdc(OFF_BUS_ADDR, 32'h20 + 32'(ti[i]), RESP_OKAY);
			rdc(OFF_VOUT, 32'(tv[i]), RESP_OKAY);
			rdc(OFF_VOUT_CEIL, 32'(tv[i]) * 11 / 10, RESP_OKAY);
			rdc(OFF_FREQ_SEL, 32'(ti[i][1:0]), RESP_OKAY);
			rdc(OFF_UVLO, 32'(ti[i]), RESP_OKAY);
		end
		wrc(OFF_BUS_ADDR, 32'h55, RESP_SLVERR);
		rdc(OFF_BUS_ADDR, 32'h21, RESP_OKAY);
		wrc(OFF_VOUT_CEIL, 32'h0, RESP_SLVERR);
		rdc(OFF_VOUT_CEIL, 32'd1650, RESP_OKAY);
		wrc(OFF_VOUT, 32'd1000, RESP_OKAY);
		rdc(OFF_VOUT, 32'd1000, RESP_OKAY);
		wrc(OFF_UVLO, 32'h2A, RESP_OKAY);
		rdc(OFF_UVLO, 32'h2A, RESP_OKAY);
		rdc(8'h3C, 32'h0, RESP_SLVERR);
		wrc(8'h3C, 32'h1, RESP_SLVERR);
		restore();
		rdc(OFF_VOUT, 32'd1500, RESP_OKAY);
		nvm_present <= 1'b1;
		nvm_vout <= 16'd900;
		nvm_freq_sel <= 2'h3;
		restore();
		rdc(OFF_VOUT, 32'd900, RESP_OKAY);
		rdc(OFF_FREQ_SEL, 32'h3, RESP_OKAY);
		rdc(OFF_VOUT_CEIL, 32'd1650, RESP_OKAY);
		kind <= {4{KIND_LOW}};
		restore();
		rdc(OFF_VOUT, 32'd1200, RESP_OKAY);
		wrc(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
		rdc(OFF_IRQ_STATUS, 32'h1, RESP_OKAY);
		chk(32'(irq), 32'h0);
		restore();
		@(negedge aclk);
		chk(32'(irq), 32'h1);
		rdc(OFF_IRQ_STATUS, 32'h1, RESP_OKAY);
		@(negedge aclk);
		chk(32'(irq), 32'h0);
		wrc(OFF_UV_THRESH, 32'd1000, RESP_OKAY);
		wrc(OFF_IRQ_MASK, 32'h2, RESP_OKAY);
		enable_pin <= 1'b1;
		err_valid <= 1'b1;
		err_sample <= 12'sd100;
		vm_valid <= 1'b1;
		vout_meas <= 16'd500;
		n_hs = 0;
		n_ls = 0;
		for (int i = 0; i < 400; i++) begin
			@(negedge aclk);
			if (hs_on === 1'b1) n_hs++;
			if (ls_on === 1'b1) n_ls++;
		end
		chk(32'(n_hs > 0), 32'h1);
		// At least nine whole periods of 40, each with 6 low-side cycles
		chk(32'(n_ls >= 54), 32'h1);
		chk(32'(irq), 32'h1);
		rdc(OFF_IRQ_STATUS, 32'h2, RESP_OKAY);
		wrc(OFF_OV_THRESH, 32'd400, RESP_OKAY);
		rdc(OFF_IRQ_STATUS, 32'h6, RESP_OKAY);
		vm_valid <= 1'b0;
		restore();
		enable_pin <= 1'b0;
		err_valid <= 1'b0;
		conclude();
	end
endmodule // mmpcl_loader_tb_top

bind mmpcl_loader mmpcl_loader_sva #(.LOAD_CYCLES_P(LOAD_CYCLES_P)) chk_u (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .high_side_on(high_side_on),
	.low_side_on(low_side_on), .config_ready(config_ready));
